// ===== core/vlms_gain.sv
// Linear-format gain: unsigned value times signed mantissa times two to a signed exponent
`timescale 1ns/1ns
module vlms_gain
(
   input  wire logic [15:0] value,     // Unsigned value to scale
   input  wire logic [15:0] gain,      // Exponent and mantissa word
   output logic      [15:0] result     // Scaled value, clamped to 0..ffff
);

   // ***************************************************
   // Scaling
   // ***************************************************
   logic signed [27:0] product;
   logic signed [4:0]  exponent;
   logic signed [43:0] shifted;

   always_comb
   begin
      product  = $signed({1'b0, value})
                 * $signed(gain[vlms_pkg::GAIN_MANT_MSB:0]);
      exponent = $signed(gain[vlms_pkg::GAIN_EXP_MSB:vlms_pkg::GAIN_EXP_LSB]);
      if (exponent[4])
         shifted = 44'(product) >>> (-exponent);
      else
         shifted = 44'(product) <<< exponent;
      // Negative results floor at zero, large ones saturate
      if (shifted < 0)
         result = 16'h0000;
      else if (shifted > 44'sh0000000ffff)
         result = 16'hffff;
      else
         result = shifted[15:0];
   end

endmodule

// ===== core/vlms_limit_cmp.sv
// One threshold comparator, tripping above or below its limit
`timescale 1ns/1ns
module vlms_limit_cmp
#(
   parameter bit TRIP_ABOVE = 1'b1     // 1: trip above limit, 0: below
)
(
   input  wire logic [15:0] sensed,    // Sensed rail mantissa
   input  wire logic [15:0] limit,     // Threshold mantissa, same exponent
   output logic             trip       // Condition present
);

   // ***************************************************
   // Compare
   // ***************************************************
   always_comb
   begin
      if (TRIP_ABOVE)
         trip = (sensed > limit);
      else
         trip = (sensed < limit);
   end

endmodule

// ===== core/vlms_pkg.sv
// Command codes, field layouts, reset values and states for the rail limit block
package vlms_pkg;

   // ***************************************************
   // Command codes
   // ***************************************************
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_DATA_FORMAT  = 8'h20;
   localparam logic [7:0] CMD_VOLT_COMMAND = 8'h21;
   localparam logic [7:0] CMD_OFFSET_TRIM  = 8'h22;
   localparam logic [7:0] CMD_MARGIN_HIGH  = 8'h25;
   localparam logic [7:0] CMD_MARGIN_LOW   = 8'h26;
   localparam logic [7:0] CMD_LOOP_GAIN    = 8'h29;
   localparam logic [7:0] CMD_MON_GAIN     = 8'h2a;
   localparam logic [7:0] CMD_OV_FAULT     = 8'h40;
   localparam logic [7:0] CMD_OV_WARN      = 8'h42;
   localparam logic [7:0] CMD_UV_WARN      = 8'h43;
   localparam logic [7:0] CMD_UV_FAULT     = 8'h44;
   localparam logic [7:0] CMD_SUM_BYTE     = 8'h78;
   localparam logic [7:0] CMD_SUM_WORD     = 8'h79;
   localparam logic [7:0] CMD_RAIL_STATUS  = 8'h7a;
   localparam logic [7:0] CMD_READ_VOLTAGE = 8'h8b;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int RAIL_OV_FAULT_BIT = 7;
   localparam int RAIL_OV_WARN_BIT  = 6;
   localparam int RAIL_UV_WARN_BIT  = 5;
   localparam int RAIL_UV_FAULT_BIT = 4;
   localparam int SUM_OV_FAULT_BIT  = 5;
   localparam int SUM_CML_BIT       = 1;
   localparam int SUM_RAIL_BIT      = 15;
   localparam int FORMAT_EXP_MSB    = 4;
   localparam int GAIN_EXP_MSB      = 15;
   localparam int GAIN_EXP_LSB      = 11;
   localparam int GAIN_MANT_MSB     = 10;

   // ***************************************************
   // Reset values
   // ***************************************************
   localparam logic [4:0]  RST_EXPONENT = 5'h00;
   localparam logic [15:0] RST_WORD     = 16'h0000;
   localparam logic [15:0] RST_GAIN     = 16'h0001;
   localparam logic [15:0] RST_OV_LIMIT = 16'hffff;
   localparam logic [15:0] RST_UV_LIMIT = 16'h0000;

   // ***************************************************
   // Command port states
   // ***************************************************
   typedef enum logic [1:0] {
      VLMS_IDLE  = 2'b01,
      VLMS_REPLY = 2'b10
   } vlms_state_t;

endpackage

// ===== core/vlms_regs.sv
// Rail set points, gains, limits and sticky status behind a decoded command port
//
// Functional notes
// - The signed 16-bit offset trim is added to the commanded voltage value.
// - Margin-high is a 16-bit unsigned mantissa using the data-format exponent bits 4:0.
// - Margin-low is a 16-bit unsigned mantissa using the same shared exponent.
// - The reference is the trimmed commanded voltage times the loop gain (exp 15:11, mantissa 10:0).
// - The voltage reading is the sensed rail input times the monitor gain, same layout.
// - An overvoltage fault is raised when the sensed input exceeds the fault limit.
// - An overvoltage warning is raised when the sensed input exceeds the warning limit.
// - An undervoltage warning is raised when the sensed input falls below its limit.
// - An undervoltage fault is raised when the sensed input falls below its limit.
// - Rail status holds OV fault, OV warning, UV warning, UV fault in bits 7 to 4.
// - The summary byte shows OV fault in bit 5 and the communication event in bit 1.
// - Summary word bit 15 is the OR of all rail status bits.
// - The summary word repeats OV fault in bit 5 and the communication event in bit 1.
// - The shared exponent is a 5-bit two's complement value in data-format bits 4:0.
// - The clear-faults command, issued with cmd_write 0, clears all three status registers at once, except rail bits whose limit is still crossed, which set again.
`timescale 1ns/1ns
module vlms_regs
(
   input  wire logic        clk,               // 50 MHz clock
   input  wire logic        reset_n,           // Asynchronous reset, active low
   input  wire logic        cmd_valid,         // Command request
   input  wire logic        cmd_write,         // 1: write, 0: read or send
   input  wire logic [7:0]  cmd_code,          // Command code
   input  wire logic [15:0] cmd_wdata,         // Write data
   input  wire logic [15:0] sensed_rail_input, // Sensed rail mantissa
   output logic             cmd_ready,         // Idle, request may be taken
   output logic             resp_valid,        // Answer pulse
   output logic             resp_error,        // Command not supported
   output logic [15:0]      resp_data,         // Read data
   output logic [15:0]      reference_out,     // Internal reference
   output logic [15:0]      reading_out,       // Voltage reading
   output logic [15:0]      margin_high_out,   // Margin-high mantissa
   output logic [15:0]      margin_low_out,    // Margin-low mantissa
   output logic [4:0]       exponent_out,      // Shared exponent
   output logic [7:0]       rail_status_out    // Rail status byte
);

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      vlms_pkg::vlms_state_t state;
      logic [4:0]            exponent;
      logic [15:0]           command;
      logic [15:0]           trim;
      logic [15:0]           mhigh;
      logic [15:0]           mlow;
      logic [15:0]           loop_gain;
      logic [15:0]           mon_gain;
      logic [15:0]           ov_fault;
      logic [15:0]           ov_warn;
      logic [15:0]           uv_warn;
      logic [15:0]           uv_fault;
      logic [3:0]            rail;
      logic                  cml;
      logic                  resp_valid;
      logic                  resp_error;
      logic [15:0]           resp_data;
      logic [15:0]           reference;
      logic [15:0]           reading;
   } vlms_regs_t;

   vlms_regs_t cur;
   vlms_regs_t next_cur;

   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic logic [15:0] clamp17(input logic signed [17:0] v);
      if (v < 0)
         return 16'h0000;
      else if (v > 18'sh0ffff)
         return 16'hffff;
      else
         return v[15:0];
   endfunction

   function automatic logic [7:0] rail_byte(input logic [3:0] r);
      rail_byte = {r, 4'h0};
   endfunction

   // ***************************************************
   // Datapath
   // ***************************************************
   logic [15:0] target;
   logic [15:0] ref_val;
   logic [15:0] read_val;
   logic [3:0]  trip;
   logic [15:0] limits [4];

   always_comb
   begin
      target = clamp17($signed({2'b00, cur.command})
                       + $signed({{2{cur.trim[15]}}, cur.trim}));
   end

   vlms_gain u_loop_gain
   (
      .value  (target),
      .gain   (cur.loop_gain),
      .result (ref_val)
   );

   vlms_gain u_mon_gain
   (
      .value  (sensed_rail_input),
      .gain   (cur.mon_gain),
      .result (read_val)
   );

   // Order matches rail status bits 3:0 -> 7:4: UV fault, UV warn, OV warn, OV fault
   assign limits[0] = cur.uv_fault;
   assign limits[1] = cur.uv_warn;
   assign limits[2] = cur.ov_warn;
   assign limits[3] = cur.ov_fault;

   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_cmp
         vlms_limit_cmp #(.TRIP_ABOVE(i >= 2)) u_cmp
         (
            .sensed (sensed_rail_input),
            .limit  (limits[i]),
            .trip   (trip[i])
         );
      end
   endgenerate

   // ***************************************************
   // Next state
   // ***************************************************
   logic [7:0]  sum_byte;
   logic [15:0] sum_word;
   logic        clear_all;
   logic        known;

   always_comb
   begin
      next_cur = cur;
      next_cur.resp_valid = 1'b0;
      next_cur.resp_error = 1'b0;
      next_cur.reference = ref_val;
      next_cur.reading = read_val;
      clear_all = 1'b0;
      known = 1'b1;
      sum_byte = 8'h00;
      sum_byte[vlms_pkg::SUM_OV_FAULT_BIT] = cur.rail[3];
      sum_byte[vlms_pkg::SUM_CML_BIT] = cur.cml;
      sum_word = {8'h00, sum_byte};
      sum_word[vlms_pkg::SUM_RAIL_BIT] = |rail_byte(cur.rail);
      case (cur.state)
         vlms_pkg::VLMS_IDLE:
         begin
            if (cmd_valid)
            begin
               next_cur.state = vlms_pkg::VLMS_REPLY;
               next_cur.resp_valid = 1'b1;
               next_cur.resp_data = 16'h0000;
               case (cmd_code)
                  vlms_pkg::CMD_CLEAR_FAULTS:
                     clear_all = !cmd_write;
                  vlms_pkg::CMD_DATA_FORMAT:
                  begin
                     next_cur.resp_data = {11'h000, cur.exponent};
                     if (cmd_write)
                        next_cur.exponent = cmd_wdata[vlms_pkg::FORMAT_EXP_MSB:0];
                  end
                  vlms_pkg::CMD_VOLT_COMMAND:
                  begin
                     next_cur.resp_data = cur.command;
                     if (cmd_write)
                        next_cur.command = cmd_wdata;
                  end
                  vlms_pkg::CMD_OFFSET_TRIM:
                  begin
                     next_cur.resp_data = cur.trim;
                     if (cmd_write)
                        next_cur.trim = cmd_wdata;
                  end
                  vlms_pkg::CMD_MARGIN_HIGH:
                  begin
                     next_cur.resp_data = cur.mhigh;
                     if (cmd_write)
                        next_cur.mhigh = cmd_wdata;
                  end
                  vlms_pkg::CMD_MARGIN_LOW:
                  begin
                     next_cur.resp_data = cur.mlow;
                     if (cmd_write)
                        next_cur.mlow = cmd_wdata;
                  end
                  vlms_pkg::CMD_LOOP_GAIN:
                  begin
                     next_cur.resp_data = cur.loop_gain;
                     if (cmd_write)
                        next_cur.loop_gain = cmd_wdata;
                  end
                  vlms_pkg::CMD_MON_GAIN:
                  begin
                     next_cur.resp_data = cur.mon_gain;
                     if (cmd_write)
                        next_cur.mon_gain = cmd_wdata;
                  end
                  vlms_pkg::CMD_OV_FAULT:
                  begin
                     next_cur.resp_data = cur.ov_fault;
                     if (cmd_write)
                        next_cur.ov_fault = cmd_wdata;
                  end
                  vlms_pkg::CMD_OV_WARN:
                  begin
                     next_cur.resp_data = cur.ov_warn;
                     if (cmd_write)
                        next_cur.ov_warn = cmd_wdata;
                  end
                  vlms_pkg::CMD_UV_WARN:
                  begin
                     next_cur.resp_data = cur.uv_warn;
                     if (cmd_write)
                        next_cur.uv_warn = cmd_wdata;
                  end
                  vlms_pkg::CMD_UV_FAULT:
                  begin
                     next_cur.resp_data = cur.uv_fault;
                     if (cmd_write)
                        next_cur.uv_fault = cmd_wdata;
                  end
                  vlms_pkg::CMD_SUM_BYTE:
                  begin
                     next_cur.resp_data = {8'h00, sum_byte};
                     if (cmd_write && cmd_wdata[vlms_pkg::SUM_OV_FAULT_BIT])
                        next_cur.rail[3] = 1'b0;
                     if (cmd_write && cmd_wdata[vlms_pkg::SUM_CML_BIT])
                        next_cur.cml = 1'b0;
                  end
                  vlms_pkg::CMD_SUM_WORD:
                  begin
                     next_cur.resp_data = sum_word;
                     if (cmd_write && cmd_wdata[vlms_pkg::SUM_OV_FAULT_BIT])
                        next_cur.rail[3] = 1'b0;
                     if (cmd_write && cmd_wdata[vlms_pkg::SUM_CML_BIT])
                        next_cur.cml = 1'b0;
                  end
                  vlms_pkg::CMD_RAIL_STATUS:
                  begin
                     next_cur.resp_data = {8'h00, rail_byte(cur.rail)};
                     known = !cmd_write;
                  end
                  vlms_pkg::CMD_READ_VOLTAGE:
                  begin
                     next_cur.resp_data = cur.reading;
                     known = !cmd_write;
                  end
                  default:
                     known = 1'b0;
               endcase
               // Writes and refused commands answer with zero data
               if (cmd_write || !known)
                  next_cur.resp_data = 16'h0000;
               next_cur.resp_error = !known;
            end
         end
         vlms_pkg::VLMS_REPLY:
            next_cur.state = vlms_pkg::VLMS_IDLE;
         default:
            next_cur.state = vlms_pkg::VLMS_IDLE;
      endcase
      // Clears first, then fresh events, so a set in the clearing cycle survives
      if (clear_all)
      begin
         next_cur.rail = 4'h0;
         next_cur.cml = 1'b0;
      end
      next_cur.rail = next_cur.rail | trip;
      if (cur.state == vlms_pkg::VLMS_IDLE && cmd_valid && !known)
         next_cur.cml = 1'b1;
   end

   // ***************************************************
   // Registers
   // ***************************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cur <= '{state:      vlms_pkg::VLMS_IDLE,
                  exponent:   vlms_pkg::RST_EXPONENT,
                  command:    vlms_pkg::RST_WORD,
                  trim:       vlms_pkg::RST_WORD,
                  mhigh:      vlms_pkg::RST_WORD,
                  mlow:       vlms_pkg::RST_WORD,
                  loop_gain:  vlms_pkg::RST_GAIN,
                  mon_gain:   vlms_pkg::RST_GAIN,
                  ov_fault:   vlms_pkg::RST_OV_LIMIT,
                  ov_warn:    vlms_pkg::RST_OV_LIMIT,
                  uv_warn:    vlms_pkg::RST_UV_LIMIT,
                  uv_fault:   vlms_pkg::RST_UV_LIMIT,
                  rail:       4'h0,
                  cml:        1'b0,
                  resp_valid: 1'b0,
                  resp_error: 1'b0,
                  resp_data:  vlms_pkg::RST_WORD,
                  reference:  vlms_pkg::RST_WORD,
                  reading:    vlms_pkg::RST_WORD};
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   assign cmd_ready       = cur.state[0];
   assign resp_valid      = cur.resp_valid;
   assign resp_error      = cur.resp_error;
   assign resp_data       = cur.resp_data;
   assign reference_out   = cur.reference;
   assign reading_out     = cur.reading;
   assign margin_high_out = cur.mhigh;
   assign margin_low_out  = cur.mlow;
   assign exponent_out    = cur.exponent;
   assign rail_status_out = {cur.rail, 4'h0};

endmodule

// ===== tb/tb.sv
// Self-checking testbench of the rail limit block
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic cmd_valid, cmd_write, cmd_ready, resp_valid, resp_error, e, v;
   logic [7:0] cmd_code, rail_status_out;
   logic [15:0] cmd_wdata, resp_data, reference_out, reading_out, q;
   logic [15:0] margin_high_out, margin_low_out;
   logic [15:0] sensed_rail_input = 16'h8000;
   logic [4:0] exponent_out;
   int n_fail = 0;
   int check_count = 0;
   localparam logic [7:0] CODES [9] = '{8'h22, 8'h25, 8'h26, 8'h29, 8'h2a, 8'h40, 8'h42,
                                        8'h43, 8'h44};
   localparam logic [15:0] RSTS [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0001,
                                        16'hffff, 16'hffff, 16'h0000, 16'h0000};
   localparam logic [15:0] SENS [5] = '{16'h9000, 16'h9001, 16'h7800, 16'h77ff, 16'h6fff};
   localparam logic [7:0] RAIL [5] = '{8'h40, 8'hc0, 8'h00, 8'h20, 8'h30};

   always #10 clk = ~clk;

   vlms_regs DUT
   (
      .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .sensed_rail_input(sensed_rail_input),
      .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_error(resp_error),
      .resp_data(resp_data), .reference_out(reference_out), .reading_out(reading_out),
      .margin_high_out(margin_high_out), .margin_low_out(margin_low_out),
      .exponent_out(exponent_out), .rail_status_out(rail_status_out)
   );
   vlms_host host
   (
      .clk(clk), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_error(resp_error),
      .resp_data(resp_data), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata)
   );

   // ***************************************************
   // Compare and access helpers
   // ***************************************************
   task chk16(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask
   task wr(input logic [7:0] c, input logic [15:0] d);
      host.xfer(1'b1, c, d, q, e, v);
      chk1(v, 1'b1);
      chk1(e, 1'b0);
      chk16(q, 16'h0000);
   endtask
   task rd(input logic [7:0] c, input logic [15:0] exp);
      host.xfer(1'b0, c, 16'h0000, q, e, v);
      chk1(v, 1'b1);
      chk16(q, exp);
   endtask
   task clr;
      host.xfer(1'b0, vlms_pkg::CMD_CLEAR_FAULTS, 16'h0000, q, e, v);
      chk1(e, 1'b0);
   endtask
   task settle;
      repeat (2) @(negedge clk);
   endtask

   // ***************************************************
   // Scenarios
   // ***************************************************
   task t_regs;
      for (int i = 0; i < 9; i++)
      begin
         rd(CODES[i], RSTS[i]);
         wr(CODES[i], {CODES[i], 8'ha5});
         rd(CODES[i], {CODES[i], 8'ha5});
         wr(CODES[i], RSTS[i]);
      end
      clr;
      wr(8'h25, 16'hfe34);
      wr(8'h26, 16'h0567);
      wr(8'h20, 16'h00f3);
      settle;
      chk16(margin_high_out, 16'hfe34);
      chk16(margin_low_out, 16'h0567);
      chk16({11'h000, exponent_out}, 16'h0013);
      rd(8'h20, 16'h0013);
   endtask

   task t_gain;
      sensed_rail_input = 16'h0100;
      wr(8'h2a, 16'h0002);
      settle;
      chk16(reading_out, 16'h0200);
      wr(8'h2a, 16'hf803);
      rd(8'h8b, 16'h0180);
      wr(8'h2a, 16'h07ff);
      settle;
      chk16(reading_out, 16'h0000);
      wr(8'h2a, 16'h0001);
      wr(8'h21, 16'h1000);
      wr(8'h22, 16'hff00);
      settle;
      chk16(reference_out, 16'h0f00);
      wr(8'h29, 16'h0003);
      settle;
      chk16(reference_out, 16'h2d00);
      wr(8'h29, 16'h0001);
      wr(8'h22, 16'h0000);
      sensed_rail_input = 16'h8000;
      settle;
      clr;
   endtask

   task t_limits;
      logic [7:0] x;
      wr(8'h40, 16'h9000);
      wr(8'h42, 16'h8800);
      wr(8'h43, 16'h7800);
      wr(8'h44, 16'h7000);
      clr;
      for (int i = 0; i < 5; i++)
      begin
         x = RAIL[i];
         sensed_rail_input = SENS[i];
         settle;
         sensed_rail_input = 16'h8000;
         settle;
         chk16({8'h00, rail_status_out}, {8'h00, x});
         rd(8'h7a, {8'h00, x});
         rd(8'h78, {10'h000, x[7], 5'h00});
         rd(8'h79, {|x, 9'h000, x[7], 5'h00});
         clr;
         settle;
         chk16({8'h00, rail_status_out}, 16'h0000);
      end
      sensed_rail_input = 16'h9001;
      settle;
      clr;
      settle;
      chk16({8'h00, rail_status_out}, 16'h00c0);
      sensed_rail_input = 16'h8000;
      settle;
      clr;
   endtask

   task t_cml;
      host.xfer(1'b0, 8'h55, 16'h0000, q, e, v);
      chk1(e, 1'b1);
      chk16(q, 16'h0000);
      host.xfer(1'b1, 8'h8b, 16'h1234, q, e, v);
      chk1(e, 1'b1);
      chk16(q, 16'h0000);
      host.xfer(1'b1, 8'h7a, 16'hffff, q, e, v);
      chk1(e, 1'b1);
      chk16(q, 16'h0000);
      rd(8'h78, 16'h0002);
      rd(8'h79, 16'h0002);
      wr(8'h78, 16'h0002);
      rd(8'h78, 16'h0000);
      host.xfer(1'b0, 8'h55, 16'h0000, q, e, v);
      clr;
      rd(8'h79, 16'h0000);
   endtask

   task final_report;
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      t_regs;
      t_gain;
      t_limits;
      t_cml;
      final_report;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report;
   end
endmodule

// ===== tb/vlms_host.sv
// Host model issuing commands on the decoded command port
`timescale 1ns/1ns
module vlms_host
(
   input  wire logic        clk,        // Clock
   input  wire logic        cmd_ready,  // Idle
   input  wire logic        resp_valid, // Answer pulse
   input  wire logic        resp_error, // Unsupported command
   input  wire logic [15:0] resp_data,  // Read data
   output logic             cmd_valid,  // Request
   output logic             cmd_write,  // Write flag
   output logic [7:0]       cmd_code,   // Command code
   output logic [15:0]      cmd_wdata   // Write data
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code  = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // One request, held until taken, then released with inverted qualifiers
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [15:0] q, output logic e, output logic v);
      int n;
      n = 0;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_code  = c;
      cmd_wdata = d;
      while (cmd_ready !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_write = ~w;
      cmd_code  = ~c;
      cmd_wdata = ~d;
      q = resp_data;
      e = resp_error;
      v = resp_valid;
   endtask
endmodule

// ===== tb/vlms_regs_properties.sv
// Assertions on the command port and rail status flags of the rail limit block
`timescale 1ns/1ns
module vlms_regs_properties
(
   input  wire logic        clk,               // Clock
   input  wire logic        reset_n,           // Asynchronous reset, active low
   input  wire logic        cmd_valid,         // Command request
   input  wire logic        cmd_write,         // Write flag
   input  wire logic [7:0]  cmd_code,          // Command code
   input  wire logic [15:0] cmd_wdata,         // Write data
   input  wire logic [15:0] sensed_rail_input, // Sensed rail mantissa
   input  wire logic        cmd_ready,         // Idle
   input  wire logic        resp_valid,        // Answer pulse
   input  wire logic        resp_error,        // Unsupported command
   input  wire logic [15:0] resp_data,         // Read data
   input  wire logic [7:0]  rail_status_out    // Rail status byte
);
   logic [15:0] ovf_lim;
   logic [15:0] uvf_lim;
   logic        take;
   logic        clr_take;
   logic        w1c_take;

   assign take = cmd_valid && cmd_ready;
   assign clr_take = take && !cmd_write && cmd_code == vlms_pkg::CMD_CLEAR_FAULTS;
   assign w1c_take = take && cmd_write && cmd_code[7:1] == 7'h3c;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // ***************************************************
   // Shadows of the fault limits
   // ***************************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ovf_lim <= vlms_pkg::RST_OV_LIMIT;
         uvf_lim <= vlms_pkg::RST_UV_LIMIT;
      end
      else if (take && cmd_write && cmd_code == vlms_pkg::CMD_OV_FAULT)
         ovf_lim <= cmd_wdata;
      else if (take && cmd_write && cmd_code == vlms_pkg::CMD_UV_FAULT)
         uvf_lim <= cmd_wdata;
   end

   sequence s_take;
      take;
   endsequence
   sequence s_reply;
      resp_valid && !cmd_ready ##1 !resp_valid && cmd_ready;
   endsequence

   // ***************************************************
   // Assertions
   // ***************************************************
   a_reply_shape: assert property (s_take |=> s_reply)
      else $error("reply not one pulse after take");
   a_no_stray: assert property (!take |=> !resp_valid)
      else $error("reply without request");
   a_err_data: assert property (resp_error |-> resp_valid && resp_data == 16'h0000)
      else $error("error reply carries data");
   a_rail_reserved: assert property (rail_status_out[3:0] == 4'h0)
      else $error("reserved rail bits set");
   a_ovf_trip: assert property (sensed_rail_input > ovf_lim |=> rail_status_out[7])
      else $error("overvoltage fault not raised");
   a_uvf_trip: assert property (sensed_rail_input < uvf_lim |=> rail_status_out[4])
      else $error("undervoltage fault not raised");
   a_ovf_sticky: assert property (rail_status_out[7] && !clr_take && !w1c_take |=>
      rail_status_out[7])
      else $error("overvoltage fault lost");
   a_clear_ovf: assert property (clr_take && sensed_rail_input <= ovf_lim |=>
      !rail_status_out[7])
      else $error("clear left fault set");
   a_uvf_sticky: assert property (rail_status_out[4] && !clr_take |=> rail_status_out[4])
      else $error("undervoltage fault lost");
endmodule

bind vlms_regs vlms_regs_properties u_props
(
   .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
   .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .sensed_rail_input(sensed_rail_input),
   .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_error(resp_error),
   .resp_data(resp_data), .rail_status_out(rail_status_out)
);
